//--- hdl/adcsq_pkg.sv
package adcsq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int DMA_ADDR_W = 11;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL1 = 5'h00;
  localparam logic [4:0] ADDR_CTRL2 = 5'h01;
  localparam logic [4:0] ADDR_INSEL = 5'h02;
  localparam logic [4:0] ADDR_SCAN = 5'h03;
  localparam logic [4:0] ADDR_DMA = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h05;
  localparam logic [4:0] ADDR_SLOT_BASE = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_MANUAL = 0;
  localparam int C1_AUTO = 1;
  localparam int C1_SIMUL = 2;
  localparam int C2_ALT = 0;
  localparam int C2_BUFFER_FILL_MODE = 1;
  localparam int C2_RATE_LSB = 2;
  localparam int C2_ACTIVE_CHANNEL_COUNT_LSB = 8;
  localparam int C2_SCAN = 10;
  localparam int IS_POS1_LSB = 0;
  localparam int IS_NEG1 = 4;
  localparam int IS_GPOS1 = 5;
  localparam int IS_GNEG1_LSB = 6;
  localparam int IS_POS2_LSB = 8;
  localparam int IS_NEG2 = 12;
  localparam int IS_GPOS2 = 13;
  localparam int IS_GNEG2_LSB = 14;
  localparam int DM_EN = 0;
  localparam int DM_ORDER = 1;
  localparam int DM_LEN_LSB = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [3:0] RST_SCAN_PTR = 4'hF;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV = 3'b100
  } adcsq_state_t;

endpackage

//--- hdl/adcsq_result_mem.sv
`timescale 1ns/1ps
module adcsq_result_mem (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [3:0] rd_addr_i,
  output logic [15:0] rd_data_o
);

  logic [15:0] mem [0:15];

  // ----------------------------------------------------------------
  // Storage, no reset so it maps onto plain RAM
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= adcsq_pkg::RST_REG;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

//--- hdl/adcsq_sequencer.sv
`timescale 1ns/1ps
module adcsq_sequencer (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic trigger_i,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_result_i,
  output logic conv_start_o,
  output logic [1:0] conv_channel_o,
  output logic [3:0] sample_hold_o,
  output logic [3:0] ch0_pos_o,
  output logic ch0_neg_o,
  output logic grp_pos_o,
  output logic [1:0] grp_neg_o,
  output logic [3:0] neg_ref_o,
  output logic input_set_second_o,
  output logic conv_irq_o,
  output logic dma_req_o,
  output logic [10:0] dma_addr_o,
  output logic [15:0] dma_data_o
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic manual_sample_bit;
  logic auto_sample_en;
  logic simultaneous_sample_sel;
  logic [15:0] converter_control_2;
  logic [15:0] insel;
  logic [15:0] scan_select_mask;
  logic dma_en;
  logic dma_buffer_order_mode;
  logic [2:0] dma_buffer_length;

  logic alternate_input_en;
  logic buffer_fill_mode;
  logic [3:0] interrupt_rate_field;
  logic [1:0] active_channel_count;
  logic scan_enable;

  assign alternate_input_en = converter_control_2[adcsq_pkg::C2_ALT];
  assign buffer_fill_mode = converter_control_2[adcsq_pkg::C2_BUFFER_FILL_MODE];
  assign interrupt_rate_field = converter_control_2[adcsq_pkg::C2_RATE_LSB +: 4];
  assign active_channel_count = converter_control_2[adcsq_pkg::C2_ACTIVE_CHANNEL_COUNT_LSB +: 2];
  assign scan_enable = converter_control_2[adcsq_pkg::C2_SCAN];

  adcsq_pkg::adcsq_state_t state;
  adcsq_pkg::adcsq_state_t next_state;
  logic [1:0] cur_ch;
  logic [1:0] next_ch;
  logic start_conv;
  logic op_done;
  logic set_done;
  logic trig_take;
  logic set_sel;
  logic [3:0] scan_ptr;
  logic [3:0] op_cnt;
  logic [3:0] wr_ptr;
  logic half_sel;
  logic [10:0] word_ptr;
  logic [10:0] inorder_addr;
  logic result_take;
  logic [3:0] res_input;
  logic [10:0] len_mask;
  logic rate_hit;
  logic [1:0] last_ch;
  logic simul_eff;
  logic [3:0] active_mask;

  // ----------------------------------------------------------------
  // Trigger pin synchroniser
  // ----------------------------------------------------------------
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic trig_pulse;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= trigger_i;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  assign trig_pulse = trig_sync & ~trig_prev;

  // ----------------------------------------------------------------
  // Channel count decode
  // ----------------------------------------------------------------
  always_comb begin
    case (active_channel_count)
      2'b00: begin
        last_ch = 2'd0;
        active_mask = 4'h1;
      end
      2'b01: begin
        last_ch = 2'd1;
        active_mask = 4'h3;
      end
      default: begin
        last_ch = 2'd3;
        active_mask = 4'hF;
      end
    endcase
  end

  // Simultaneous sampling has no meaning with a single holder
  assign simul_eff = simultaneous_sample_sel & (last_ch != 2'd0);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_ch = cur_ch;
    start_conv = 1'b0;
    op_done = 1'b0;
    set_done = 1'b0;
    trig_take = 1'b0;
    case (state)
      adcsq_pkg::ST_IDLE: begin
        if (auto_sample_en || manual_sample_bit) begin
          next_state = adcsq_pkg::ST_SAMPLE;
        end
      end
      adcsq_pkg::ST_SAMPLE: begin
        if (trig_pulse) begin
          next_state = adcsq_pkg::ST_CONV;
          start_conv = 1'b1;
          trig_take = 1'b1;
        end
      end
      adcsq_pkg::ST_CONV: begin
        if (conv_done_i) begin
          if (simul_eff && cur_ch != last_ch) begin
            next_ch = cur_ch + 2'd1;
            start_conv = 1'b1;
          end else begin
            op_done = 1'b1;
            if (cur_ch == last_ch) begin
              next_ch = 2'd0;
              set_done = 1'b1;
            end else begin
              next_ch = cur_ch + 2'd1;
            end
            // Restart by itself only when auto-sampling
            next_state = auto_sample_en ? adcsq_pkg::ST_SAMPLE : adcsq_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        next_state = adcsq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= adcsq_pkg::ST_IDLE;
      cur_ch <= 2'd0;
      conv_start_o <= 1'b0;
      conv_channel_o <= 2'd0;
      sample_hold_o <= 4'h0;
    end else begin
      state <= next_state;
      cur_ch <= next_ch;
      conv_start_o <= start_conv;
      if (start_conv) begin
        conv_channel_o <= next_ch;
      end
      if (next_state == adcsq_pkg::ST_SAMPLE) begin
        sample_hold_o <= simul_eff ? active_mask : (4'h1 << next_ch);
      end else begin
        sample_hold_o <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input selection
  // ----------------------------------------------------------------
  function automatic logic [3:0] scan_next(input logic [3:0] ptr, input logic [15:0] mask);
    logic [3:0] idx;
    logic found;
    found = 1'b0;
    scan_next = ptr;
    for (int k = 1; k <= 16; k++) begin
      idx = ptr + 4'(k);
      if (!found && mask[idx]) begin
        scan_next = idx;
        found = 1'b1;
      end
    end
  endfunction

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      set_sel <= 1'b0;
    end else if (!alternate_input_en) begin
      set_sel <= 1'b0;
    end else if (set_done) begin
      set_sel <= ~set_sel;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scan_ptr <= adcsq_pkg::RST_SCAN_PTR;
    end else if (!scan_enable) begin
      scan_ptr <= scan_next(adcsq_pkg::RST_SCAN_PTR, scan_select_mask);
    end else if (conv_done_i && state == adcsq_pkg::ST_CONV && cur_ch == 2'd0) begin
      scan_ptr <= scan_next(scan_ptr, scan_select_mask);
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ch0_pos_o <= 4'h0;
      ch0_neg_o <= 1'b0;
      grp_pos_o <= 1'b0;
      grp_neg_o <= 2'b00;
      neg_ref_o <= 4'hF;
      input_set_second_o <= 1'b0;
    end else begin
      input_set_second_o <= set_sel;
      if (scan_enable) begin
        ch0_pos_o <= scan_ptr;
      end else if (set_sel) begin
        ch0_pos_o <= insel[adcsq_pkg::IS_POS2_LSB +: 4];
      end else begin
        ch0_pos_o <= insel[adcsq_pkg::IS_POS1_LSB +: 4];
      end
      if (set_sel) begin
        ch0_neg_o <= insel[adcsq_pkg::IS_NEG2];
        grp_pos_o <= insel[adcsq_pkg::IS_GPOS2];
        grp_neg_o <= insel[adcsq_pkg::IS_GNEG2_LSB +: 2];
        neg_ref_o <= {{3{~insel[adcsq_pkg::IS_GNEG2_LSB + 1]}}, ~insel[adcsq_pkg::IS_NEG2]};
      end else begin
        ch0_neg_o <= insel[adcsq_pkg::IS_NEG1];
        grp_pos_o <= insel[adcsq_pkg::IS_GPOS1];
        grp_neg_o <= insel[adcsq_pkg::IS_GNEG1_LSB +: 2];
        neg_ref_o <= {{3{~insel[adcsq_pkg::IS_GNEG1_LSB + 1]}}, ~insel[adcsq_pkg::IS_NEG1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Result routing
  // ----------------------------------------------------------------
  assign result_take = conv_done_i && (state == adcsq_pkg::ST_CONV);
  assign rate_hit = op_done && (op_cnt == interrupt_rate_field);
  assign res_input = (cur_ch == 2'd0) ? ch0_pos_o :
                     (grp_pos_o ? {2'b00, cur_ch} + 4'h2 : {2'b00, cur_ch} - 4'h1);
  assign len_mask = (11'h001 << dma_buffer_length) - 11'h001;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_cnt <= 4'h0;
      conv_irq_o <= 1'b0;
    end else begin
      conv_irq_o <= rate_hit && !dma_en;
      if (rate_hit) begin
        op_cnt <= 4'h0;
      end else if (op_done) begin
        op_cnt <= op_cnt + 4'h1;
      end
    end
  end

  // Buffer slot pointer; fill mode 1 splits the buffer into two halves
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= 4'h0;
      half_sel <= 1'b0;
    end else if (rate_hit && !dma_en) begin
      wr_ptr <= 4'h0;
      half_sel <= buffer_fill_mode ? ~half_sel : 1'b0;
    end else if (result_take && !dma_en) begin
      wr_ptr <= wr_ptr + 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_ptr <= 11'h000;
      inorder_addr <= 11'h000;
      dma_req_o <= 1'b0;
      dma_addr_o <= 11'h000;
      dma_data_o <= 16'h0000;
    end else begin
      dma_req_o <= result_take && dma_en;
      if (!dma_en) begin
        word_ptr <= 11'h000;
        inorder_addr <= 11'h000;
      end else begin
        if (rate_hit) begin
          word_ptr <= word_ptr + 11'h001;
        end
        if (result_take) begin
          inorder_addr <= inorder_addr + 11'h001;
          dma_data_o <= conv_result_i;
          if (dma_buffer_order_mode) begin
            dma_addr_o <= inorder_addr;
          end else begin
            dma_addr_o <= ((11'(res_input)) << dma_buffer_length) | (word_ptr & len_mask);
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  logic [3:0] slot_addr;
  logic [15:0] mem_q;

  assign slot_addr = buffer_fill_mode ? {half_sel, wr_ptr[2:0]} : wr_ptr;

  adcsq_result_mem u_mem (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(result_take && !dma_en),
    .wr_addr_i(slot_addr),
    .wr_data_i(conv_result_i),
    .rd_addr_i(reg_addr_i[3:0]),
    .rd_data_o(mem_q)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      manual_sample_bit <= 1'b0;
      auto_sample_en <= 1'b0;
      simultaneous_sample_sel <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == adcsq_pkg::ADDR_CTRL1) begin
      manual_sample_bit <= reg_wdata_i[adcsq_pkg::C1_MANUAL];
      auto_sample_en <= reg_wdata_i[adcsq_pkg::C1_AUTO];
      simultaneous_sample_sel <= reg_wdata_i[adcsq_pkg::C1_SIMUL];
    end else if (trig_take) begin
      manual_sample_bit <= 1'b0;
    end else if (state == adcsq_pkg::ST_IDLE && next_state == adcsq_pkg::ST_SAMPLE) begin
      manual_sample_bit <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      converter_control_2 <= adcsq_pkg::RST_REG;
      insel <= adcsq_pkg::RST_REG;
      scan_select_mask <= adcsq_pkg::RST_REG;
      dma_en <= 1'b0;
      dma_buffer_order_mode <= 1'b0;
      dma_buffer_length <= 3'b000;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        adcsq_pkg::ADDR_CTRL2: converter_control_2 <= reg_wdata_i;
        adcsq_pkg::ADDR_INSEL: insel <= reg_wdata_i;
        adcsq_pkg::ADDR_SCAN: scan_select_mask <= reg_wdata_i;
        adcsq_pkg::ADDR_DMA: begin
          dma_en <= reg_wdata_i[adcsq_pkg::DM_EN];
          dma_buffer_order_mode <= reg_wdata_i[adcsq_pkg::DM_ORDER];
          dma_buffer_length <= reg_wdata_i[adcsq_pkg::DM_LEN_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [15:0] reg_q;
  logic rd_from_mem;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_q <= adcsq_pkg::RST_REG;
      rd_from_mem <= 1'b0;
    end else begin
      rd_from_mem <= reg_rd_i && reg_addr_i[4];
      reg_q <= 16'h0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          adcsq_pkg::ADDR_CTRL1: reg_q <= {13'h0000, simultaneous_sample_sel, auto_sample_en, manual_sample_bit};
          adcsq_pkg::ADDR_CTRL2: reg_q <= converter_control_2;
          adcsq_pkg::ADDR_INSEL: reg_q <= insel;
          adcsq_pkg::ADDR_SCAN: reg_q <= scan_select_mask;
          adcsq_pkg::ADDR_DMA: reg_q <= {11'h000, dma_buffer_length, dma_buffer_order_mode, dma_en};
          adcsq_pkg::ADDR_STATUS: reg_q <= {scan_ptr, op_cnt, wr_ptr, half_sel, set_sel, cur_ch};
          default: reg_q <= 16'h0000;
        endcase
      end
    end
  end

  // Two flops meet here so slot reads need no extra cycle of latency
  assign reg_rdata_o = rd_from_mem ? mem_q : reg_q;

endmodule

//--- sim/adc_sample_convert_sequencer_tb.sv
`timescale 1ns/1ps
module adc_sample_convert_sequencer_tb;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic trigger_i = 1'b0;
  logic [3:0] latency = 4'h2;
  logic [15:0] reg_rdata_o, conv_result_i, dma_data_o, rdata;
  logic conv_done_i, conv_start_o, ch0_neg_o, grp_pos_o, input_set_second_o, conv_irq_o, dma_req_o;
  logic [1:0] conv_channel_o, grp_neg_o;
  logic [3:0] sample_hold_o, ch0_pos_o, neg_ref_o;
  logic [10:0] dma_addr_o;
  int errors = 0;
  int comparisons = 0;
  int scan_in[3] = '{0, 2, 5};

  always #25 clock_i = ~clock_i;

  adcsq_sequencer dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .trigger_i(trigger_i), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .sample_hold_o(sample_hold_o),
    .ch0_pos_o(ch0_pos_o), .ch0_neg_o(ch0_neg_o), .grp_pos_o(grp_pos_o), .grp_neg_o(grp_neg_o),
    .neg_ref_o(neg_ref_o), .input_set_second_o(input_set_second_o), .conv_irq_o(conv_irq_o),
    .dma_req_o(dma_req_o), .dma_addr_o(dma_addr_o), .dma_data_o(dma_data_o));

  adcsq_conv_model u_conv (.clock_i(clock_i), .arst_n_i(arst_n_i), .conv_start_i(conv_start_o),
    .latency_i(latency), .conv_done_o(conv_done_i), .conv_result_o(conv_result_i));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
  endtask

  // Completion is read before the edge's updates land, outputs after
  task automatic wait_until(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      if (sel != 2) #1;
      n++;
      if (n > 40) begin
        errors++;
        report_and_stop();
      end
    end while (!((sel == 0 && sample_hold_o != 4'h0) || (sel == 1 && conv_start_o === 1'b1)
                 || (sel == 2 && conv_done_i === 1'b1)));
  endtask

  task automatic start_one();
    wait_until(0);
    @(posedge clock_i);
    trigger_i <= 1'b1;
    wait_until(1);
  endtask

  task automatic finish_one(input logic exp_irq);
    @(posedge clock_i);
    trigger_i <= 1'b0;
    wait_until(2);
    // Pulses answering the completion stand only until the next edge
    #1;
    chk(16'(conv_irq_o), 16'(exp_irq));
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    wr(5'h02, 16'h0006);
    wr(5'h01, 16'h000C);
    wr(5'h00, 16'h0002);
    for (int k = 1; k <= 8; k++) begin
      start_one();
      chk(16'(ch0_pos_o), 16'h0006);
      chk(16'(input_set_second_o), 16'h0000);
      chk(16'(conv_channel_o), 16'h0000);
      finish_one(k % 4 == 0);
    end
    wr(5'h00, 16'h0001);
    start_one();
    finish_one(1'b0);
    repeat (6) @(posedge clock_i);
    #1;
    chk(16'(sample_hold_o), 16'h0000);
    $display("test single holder done");

    do_reset();
    latency <= 4'h9;
    wr(5'h02, 16'h2706);
    wr(5'h01, 16'h023D);
    wr(5'h00, 16'h0002);
    for (int k = 0; k < 16; k++) begin
      start_one();
      chk(16'(conv_channel_o), 16'(k % 4));
      if (k % 4 == 0) chk(16'(ch0_pos_o), (k % 8 < 4) ? 16'h0006 : 16'h0007);
      if (k % 4 == 1) chk(16'(grp_pos_o), 16'(k % 8 >= 4));
      if (k % 4 == 1) chk(16'(input_set_second_o), 16'(k % 8 >= 4));
      finish_one(k == 15);
    end
    for (int k = 0; k < 16; k++) begin
      rd(5'h10 + 5'(k), rdata);
      chk(rdata, {8'hC3, 8'(k + 1)});
    end
    rd(5'h08, rdata);
    chk(rdata, 16'h0000);
    rd(5'h01, rdata);
    chk(rdata, 16'h023D);
    $display("test sequential alternate done");

    for (int m = 0; m < 2; m++) begin
      do_reset();
      latency <= 4'h2;
      wr(5'h03, 16'h0025);
      wr(5'h02, 16'h0003);
      wr(5'h01, 16'h0400);
      wr(5'h04, (m == 1) ? 16'h000B : 16'h0009);
      wr(5'h00, 16'h0002);
      for (int k = 0; k < 6; k++) begin
        start_one();
        chk(16'(ch0_pos_o), 16'(scan_in[k % 3]));
        finish_one(1'b0);
        chk(16'(dma_req_o), 16'h0001);
        chk(dma_data_o, {8'hC3, 8'(k + 1)});
        chk(16'(dma_addr_o), (m == 1) ? 16'(k) : 16'(scan_in[k % 3] * 4 + k % 4));
      end
      $display("test scan transfer mode %0d done", m);
    end

    do_reset();
    latency <= 4'h2;
    wr(5'h01, 16'h0200);
    wr(5'h00, 16'h0006);
    wait_until(0);
    chk(16'(sample_hold_o), 16'h000F);
    for (int k = 0; k < 4; k++) begin
      if (k == 0) start_one();
      else chk(16'(conv_start_o), 16'h0001);
      chk(16'(conv_channel_o), 16'(k));
      chk(16'(sample_hold_o), 16'h0000);
      finish_one(k == 3);
    end
    rd(5'h13, rdata);
    chk(rdata, 16'hC304);
    $display("test simultaneous holders done");
    report_and_stop();
  end
endmodule

//--- sim/adcsq_conv_model.sv
`timescale 1ns/1ps
module adcsq_conv_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic conv_start_i,
  input wire logic [3:0] latency_i,
  output logic conv_done_o,
  output logic [15:0] conv_result_o
);
  logic busy;
  logic [3:0] wait_cnt;
  logic [7:0] start_cnt;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      start_cnt <= 8'h00;
      conv_done_o <= 1'b0;
      conv_result_o <= 16'h0000;
    end else begin
      conv_done_o <= 1'b0;
      // Result is only valid in the done cycle, so make it move otherwise
      conv_result_o <= ~conv_result_o;
      if (conv_start_i) begin
        busy <= 1'b1;
        wait_cnt <= latency_i;
        start_cnt <= start_cnt + 8'h01;
      end else if (busy) begin
        if (wait_cnt == 4'h0) begin
          busy <= 1'b0;
          conv_done_o <= 1'b1;
          conv_result_o <= {8'hC3, start_cnt};
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule

//--- sim/adcsq_sequencer_properties.sv
`timescale 1ns/1ps
module adcsq_sequencer_properties (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic trigger_i,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_result_i,
  input wire logic conv_start_o,
  input wire logic [1:0] conv_channel_o,
  input wire logic [3:0] sample_hold_o,
  input wire logic ch0_neg_o,
  input wire logic [1:0] grp_neg_o,
  input wire logic [3:0] neg_ref_o,
  input wire logic conv_irq_o,
  input wire logic dma_req_o,
  input wire logic [15:0] dma_data_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
  AST_START_CAUSE: assert property (conv_start_o |-> $past(conv_done_i) || $past(trigger_i, 3))
    else $error("conversion started without trigger or completion");
  AST_HOLD_STOPS: assert property (conv_start_o |-> !sample_hold_o[conv_channel_o])
    else $error("converting holder still sampling");
  AST_IRQ_CAUSE: assert property (conv_irq_o |-> $past(conv_done_i) ##1 !conv_irq_o)
    else $error("interrupt not tied to a completion");
  AST_DMA_DATA: assert property (dma_req_o |-> $past(conv_done_i) && dma_data_o == $past(conv_result_i))
    else $error("transfer data differs from result");
  AST_DMA_ONCE: assert property ($rose(dma_req_o) |=> !dma_req_o)
    else $error("transfer request longer than one cycle");
  AST_CH0_NEG_REF: assert property (neg_ref_o[0] == !ch0_neg_o)
    else $error("holder 0 negative reference wrong");
  AST_GRP_NEG_REF: assert property (neg_ref_o[3:1] == {3{!grp_neg_o[1]}})
    else $error("group negative reference wrong");
endmodule

bind adcsq_sequencer adcsq_sequencer_properties u_props (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .trigger_i(trigger_i), .conv_done_i(conv_done_i),
  .conv_result_i(conv_result_i), .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
  .sample_hold_o(sample_hold_o), .ch0_neg_o(ch0_neg_o), .grp_neg_o(grp_neg_o), .neg_ref_o(neg_ref_o),
  .conv_irq_o(conv_irq_o), .dma_req_o(dma_req_o), .dma_data_o(dma_data_o)
);
